/* src/rtck_core.sv */
// real-time clock timekeeping core on the special function register bus
//
// Notes on behaviour
// [R1] timebase is the 32.768 kHz crystal only
// [R2] nominal and thermal trims correct the divider
// [R3] counting continues in every low-power mode
// [R4] watchdog and pin resets keep the counters
// [R5] only power-on reset clears the counters
// [R6] registers are whole bytes, no bit access
// [R7] fixed register addresses on the bus
// [R8] protected writes need the unlock key loaded
// [R9] software loads the key before protected writes
// [R10] software zeroes the key afterwards
// [R11] midnight flag sets on rollover to zero
// [R12] midnight flag holds until software or a warm reset clears it
// [R13] 24-hour mode flags midnight once daily
// [R14] set midnight flag blocks deepest sleep entry
// [R15] day length 0: hours wrap 255 to 0
// [R16] day length 1: hours wrap 23 to 0
// [R17] day length bit survives warm resets
// [R18] base codes 00 1/128 s, 01 second
// [R19] single-shot selects one alarm or repeating
// [R20] software cannot set the alarm flag
// [R21] timer off holds interval counter at zero
// [R22] base codes 10 minute, 11 hour
`timescale 1ns/100ps
module rtck_core import rtck_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic warm_rst_n,
    input wire logic xtal_in,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic midnight_flag,
    output logic alarm_flag,
    output logic [7:0] irq_pin_config,
    output logic deep_sleep_ok
);
    rtck_state_t st;
    rtck_state_t next_st;

    logic xtal_tick;
    logic slot_tick;
    logic signed [8:0] trim_sum;
    logic signed [17:0] acc_sum;
    logic centi_tick;
    logic sec_tick;
    logic min_tick;
    logic hour_tick;
    logic day_wrap;
    logic [7:0] hour_top;
    logic base_tick;
    logic ivl_hit;
    logic unlocked;
    logic wr_cfg;
    logic [7:0] rd_mux;

    // crystal edges arrive from outside the core clock domain
    rtck_xtal_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .xtal_in(xtal_in),
        .xtal_rise(xtal_tick)
    );

    // one slot is 256 crystal edges, 1/128 s; trims apply once per slot
    assign slot_tick = xtal_tick && (st.slot_cnt == RTCK_SLOT_LAST); // see [R1]
    assign trim_sum = 9'(signed'(st.nom_trim)) + 9'(signed'(st.therm_trim));

    // fractional divider: 100 per edge, wrap at 32768 gives hundredths
    always_comb begin
        acc_sum = signed'({2'b00, st.acc});
        if (xtal_tick) begin
            acc_sum = acc_sum + RTCK_ACC_STEP; // see [R1]
        end
        if (slot_tick) begin
            acc_sum = acc_sum + 18'(trim_sum); // see [R2]
        end
        if (acc_sum < 18'sd0) begin
            acc_sum = 18'sd0;
        end
    end

    assign centi_tick = acc_sum >= RTCK_ACC_WRAP;
    assign sec_tick = centi_tick && (st.tm.centi == RTCK_CENTI_MAX);
    assign min_tick = sec_tick && (st.tm.sec == RTCK_SEC_MAX);
    assign hour_tick = min_tick && (st.tm.min == RTCK_MIN_MAX);
    assign hour_top = st.cfg.day_length_select ? RTCK_HOUR24_MAX
                                               : RTCK_HOUR256_MAX;
    // a wrap from the top hour lands on 00:00:00:00
    assign day_wrap = hour_tick && (st.tm.hour >= hour_top); // see [R15]

    always_comb begin
        case (st.cfg.interval_base_select)
            RTCK_BASE_128TH: base_tick = slot_tick; // see [R18]
            RTCK_BASE_SEC: base_tick = sec_tick; // see [R18]
            RTCK_BASE_MIN: base_tick = min_tick; // see [R22]
            RTCK_BASE_HOUR: base_tick = hour_tick; // see [R22]
            default: base_tick = 1'b0;
        endcase
    end

    // an interval of zero only fires after a full 256-count wrap
    assign ivl_hit = st.cfg.interval_timer_on && !st.ivl_done && base_tick
                     && (8'(st.ivl_cnt + 8'h01) == st.interval);

    assign unlocked = (st.key == RTCK_TIME_KEY); // see [R8]
    assign wr_cfg = sfr_wr && (sfr_addr == RTCK_ADDR_CONFIG);

    // whole-byte decode only; the bus has no bit-address path
    always_comb begin
        case (sfr_addr) // see [R6] [R7]
            RTCK_ADDR_CONFIG: rd_mux = st.cfg;
            RTCK_ADDR_CENTI: rd_mux = st.tm.centi;
            RTCK_ADDR_SEC: rd_mux = st.tm.sec;
            RTCK_ADDR_MIN: rd_mux = st.tm.min;
            RTCK_ADDR_HOUR: rd_mux = st.tm.hour;
            RTCK_ADDR_INTERVAL: rd_mux = st.interval;
            RTCK_ADDR_KEY: rd_mux = st.key;
            RTCK_ADDR_NOM_TRIM: rd_mux = st.nom_trim;
            RTCK_ADDR_THERM_TRIM: rd_mux = st.therm_trim;
            RTCK_ADDR_IRQ_CFG: rd_mux = st.irq_cfg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        next_st = st;

        // counting never looks at any power mode input
        if (xtal_tick) begin
            next_st.slot_cnt = 8'(st.slot_cnt + 8'h01); // see [R3]
        end
        next_st.acc = centi_tick ? 16'(acc_sum - RTCK_ACC_WRAP)
                                 : 16'(acc_sum);
        if (centi_tick) begin
            next_st.tm.centi = sec_tick ? 8'h00
                                        : 8'(st.tm.centi + 8'h01);
        end
        if (sec_tick) begin
            next_st.tm.sec = min_tick ? 8'h00 : 8'(st.tm.sec + 8'h01);
        end
        if (min_tick) begin
            next_st.tm.min = hour_tick ? 8'h00 : 8'(st.tm.min + 8'h01);
        end
        if (hour_tick) begin
            next_st.tm.hour = day_wrap ? 8'h00 // see [R15] [R16]
                                       : 8'(st.tm.hour + 8'h01);
        end

        // interval timer
        if (base_tick && st.cfg.interval_timer_on && !st.ivl_done) begin
            next_st.ivl_cnt = ivl_hit ? 8'h00 : 8'(st.ivl_cnt + 8'h01);
        end
        if (ivl_hit && st.cfg.single_shot_select) begin
            next_st.ivl_done = 1'b1; // see [R19]
        end

        // register writes; protected time writes beat the tick
        if (sfr_wr) begin
            case (sfr_addr)
                RTCK_ADDR_CONFIG: begin
                    next_st.cfg.day_length_select = sfr_wdata[6];
                    next_st.cfg.interval_base_select =
                        rtck_base_t'(sfr_wdata[5:4]);
                    next_st.cfg.single_shot_select = sfr_wdata[3];
                    next_st.cfg.interval_timer_on = sfr_wdata[1];
                    next_st.cfg.resv = sfr_wdata[0];
                    // flags: a written 0 clears, a written 1 is ignored
                    next_st.cfg.midnight = st.cfg.midnight && sfr_wdata[7];
                    next_st.cfg.alarm = st.cfg.alarm && sfr_wdata[2]; // see [R20]
                end
                RTCK_ADDR_CENTI: begin
                    if (unlocked) begin
                        next_st.tm.centi = sfr_wdata; // see [R8]
                        next_st.acc = 16'h0000;
                    end
                end
                RTCK_ADDR_SEC: begin
                    if (unlocked) begin
                        next_st.tm.sec = sfr_wdata; // see [R8]
                    end
                end
                RTCK_ADDR_MIN: begin
                    if (unlocked) begin
                        next_st.tm.min = sfr_wdata; // see [R8]
                    end
                end
                RTCK_ADDR_HOUR: begin
                    if (unlocked) begin
                        next_st.tm.hour = sfr_wdata; // see [R8]
                    end
                end
                RTCK_ADDR_IRQ_CFG: begin
                    if (unlocked) begin
                        next_st.irq_cfg = sfr_wdata; // see [R8]
                    end
                end
                RTCK_ADDR_INTERVAL: next_st.interval = sfr_wdata;
                RTCK_ADDR_KEY: next_st.key = sfr_wdata;
                RTCK_ADDR_NOM_TRIM: next_st.nom_trim = sfr_wdata;
                RTCK_ADDR_THERM_TRIM: next_st.therm_trim = sfr_wdata;
                default: next_st.key = st.key;
            endcase
        end

        // hardware set wins over a same-cycle software clear
        if (day_wrap) begin
            next_st.cfg.midnight = 1'b1; // see [R11] [R12] [R13]
        end
        if (ivl_hit) begin
            next_st.cfg.alarm = 1'b1; // see [R19] [R20]
        end

        // a stopped timer is held at zero and rearms a single shot
        if (!next_st.cfg.interval_timer_on) begin
            next_st.ivl_cnt = 8'h00; // see [R21]
            next_st.ivl_done = 1'b0;
        end

        if (sfr_rd) begin
            next_st.rdata = rd_mux;
        end

        // warm reset: time, divider and day length ride through
        if (!warm_rst_n) begin
            next_st.cfg = rtck_cfg_t'(RTCK_CONFIG_RST);
            next_st.cfg.day_length_select = st.cfg.day_length_select; // see [R17]
            next_st.key = RTCK_KEY_RST; // see [R4]
            next_st.irq_cfg = RTCK_IRQ_CFG_RST;
            next_st.interval = RTCK_INTERVAL_RST;
            next_st.nom_trim = RTCK_TRIM_RST;
            next_st.therm_trim = RTCK_TRIM_RST;
            next_st.ivl_cnt = 8'h00;
            next_st.ivl_done = 1'b0;
            next_st.rdata = RTCK_RDATA_RST;
        end

        next_st.sleep_ok = !next_st.cfg.midnight; // see [R14]
    end

    // only the power-on reset reaches the time counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0; // see [R5]
            st.cfg <= rtck_cfg_t'(RTCK_CONFIG_RST);
            st.sleep_ok <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign midnight_flag = st.cfg.midnight;
    assign alarm_flag = st.cfg.alarm;
    assign irq_pin_config = st.irq_cfg;
    assign deep_sleep_ok = st.sleep_ok;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence locked_irq_write;
        sfr_wr && (sfr_addr == RTCK_ADDR_IRQ_CFG) && !unlocked && warm_rst_n;
    endsequence

    sequence unlocked_irq_write;
        sfr_wr && (sfr_addr == RTCK_ADDR_IRQ_CFG) && unlocked && warm_rst_n;
    endsequence

    sequence quiet_cfg;
        !wr_cfg && warm_rst_n;
    endsequence

    key_lock_hold_a: assert property ( // see [R8]
        locked_irq_write |=> $stable(irq_pin_config))
        else $error("locked write changed irq config");

    key_unlock_write_a: assert property ( // see [R8]
        unlocked_irq_write |=> irq_pin_config == $past(sfr_wdata))
        else $error("unlocked write did not land");

    midnight_set_a: assert property ( // see [R11]
        day_wrap && !sfr_wr && warm_rst_n |=> midnight_flag && st.tm == '0)
        else $error("rollover did not set midnight");

    midnight_hold_a: assert property ( // see [R12]
        (midnight_flag and quiet_cfg) |=> midnight_flag)
        else $error("midnight flag dropped by itself");

    hour_wrap24_a: assert property ( // see [R16]
        hour_tick && st.cfg.day_length_select
        && (st.tm.hour == RTCK_HOUR24_MAX) && !sfr_wr
        |=> st.tm.hour == 8'h00)
        else $error("hour did not wrap after 23");

    hour_wrap256_a: assert property ( // see [R15]
        hour_tick && !st.cfg.day_length_select
        && (st.tm.hour == 8'hfe) && !sfr_wr
        |=> st.tm.hour == RTCK_HOUR256_MAX)
        else $error("hour stopped short of 255");

    timer_off_zero_a: assert property ( // see [R21]
        !st.cfg.interval_timer_on [*2] |-> st.ivl_cnt == 8'h00)
        else $error("interval counter runs while off");

    alarm_no_sw_a: assert property ( // see [R20]
        !alarm_flag && !ivl_hit |=> !alarm_flag)
        else $error("alarm set without interval elapse");

    single_shot_a: assert property ( // see [R19]
        ((ivl_hit && st.cfg.single_shot_select) and quiet_cfg)
        |=> !ivl_hit [*8])
        else $error("single shot fired twice");

    sleep_block_a: assert property ( // see [R14]
        midnight_flag |-> !deep_sleep_ok)
        else $error("deep sleep allowed with midnight set");

    warm_retain_a: assert property ( // see [R4] [R17]
        !warm_rst_n && !centi_tick && !sfr_wr
        |=> $stable(st.tm) && $stable(st.cfg.day_length_select))
        else $error("warm reset disturbed time or day length");

    hour_wrap255_a: assert property ( // see [R15]
        hour_tick && !st.cfg.day_length_select
        && (st.tm.hour == RTCK_HOUR256_MAX) && !sfr_wr
        |=> st.tm.hour == 8'h00)
        else $error("hour did not wrap after 255");

    centi_step_a: assert property ( // see [R1]
        centi_tick && !sec_tick && !sfr_wr
        |=> st.tm.centi == 8'($past(st.tm.centi) + 8'h01))
        else $error("hundredths did not step on a divider wrap");

    alarm_set_a: assert property ( // see [R19]
        ivl_hit && warm_rst_n |=> alarm_flag)
        else $error("interval elapse did not set alarm");

    alarm_hold_a: assert property ( // see [R20]
        (alarm_flag and quiet_cfg) |=> alarm_flag)
        else $error("alarm flag dropped by itself");
endmodule : rtck_core

/* include/rtck_pkg.sv */
// constants and carrier types for the real-time clock timekeeping core
package rtck_pkg;

    // register byte addresses on the special function register bus
    localparam logic [7:0] RTCK_ADDR_CONFIG = 8'ha1;
    localparam logic [7:0] RTCK_ADDR_CENTI = 8'ha2;
    localparam logic [7:0] RTCK_ADDR_SEC = 8'ha3;
    localparam logic [7:0] RTCK_ADDR_MIN = 8'ha4;
    localparam logic [7:0] RTCK_ADDR_HOUR = 8'ha5;
    localparam logic [7:0] RTCK_ADDR_INTERVAL = 8'ha6;
    localparam logic [7:0] RTCK_ADDR_KEY = 8'hc1;
    localparam logic [7:0] RTCK_ADDR_NOM_TRIM = 8'hf6;
    localparam logic [7:0] RTCK_ADDR_THERM_TRIM = 8'hf7;
    localparam logic [7:0] RTCK_ADDR_IRQ_CFG = 8'hff;

    // unlock value for the timekeeping registers
    localparam logic [7:0] RTCK_TIME_KEY = 8'hea;

    // reset values
    localparam logic [7:0] RTCK_CONFIG_RST = 8'h01;
    localparam logic [7:0] RTCK_KEY_RST = 8'h00;
    localparam logic [7:0] RTCK_IRQ_CFG_RST = 8'h00;
    localparam logic [7:0] RTCK_INTERVAL_RST = 8'h00;
    localparam logic [7:0] RTCK_TRIM_RST = 8'h00;
    localparam logic [7:0] RTCK_RDATA_RST = 8'h00;

    // counter limits
    localparam logic [7:0] RTCK_CENTI_MAX = 8'h63;
    localparam logic [7:0] RTCK_SEC_MAX = 8'h3b;
    localparam logic [7:0] RTCK_MIN_MAX = 8'h3b;
    localparam logic [7:0] RTCK_HOUR24_MAX = 8'h17;
    localparam logic [7:0] RTCK_HOUR256_MAX = 8'hff;

    // crystal rate and the fractional divider down to hundredths
    localparam int unsigned RTCK_XTAL_HZ = 32768;
    localparam int unsigned RTCK_CENTI_PER_S = 100;
    localparam logic signed [17:0] RTCK_ACC_WRAP = 18'(RTCK_XTAL_HZ);
    localparam logic signed [17:0] RTCK_ACC_STEP = 18'(RTCK_CENTI_PER_S);
    // count of the last crystal tick in a 1/128 s slot, also the trim period
    localparam logic [7:0] RTCK_SLOT_LAST = 8'(RTCK_XTAL_HZ / 128 - 1);

    typedef enum logic [1:0] {
        RTCK_BASE_128TH = 2'h0,
        RTCK_BASE_SEC = 2'h1,
        RTCK_BASE_MIN = 2'h2,
        RTCK_BASE_HOUR = 2'h3
    } rtck_base_t;

    typedef struct packed {
        logic midnight;
        logic day_length_select;
        rtck_base_t interval_base_select;
        logic single_shot_select;
        logic alarm;
        logic interval_timer_on;
        logic resv;
    } rtck_cfg_t;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
        logic [7:0] centi;
    } rtck_time_t;

    typedef struct packed {
        rtck_time_t tm;
        rtck_cfg_t cfg;
        logic [7:0] key;
        logic [7:0] irq_cfg;
        logic [7:0] nom_trim;
        logic [7:0] therm_trim;
        logic [7:0] interval;
        logic [15:0] acc;
        logic [7:0] slot_cnt;
        logic [7:0] ivl_cnt;
        logic ivl_done;
        logic [7:0] rdata;
        logic sleep_ok;
    } rtck_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } rtck_sync_t;

endpackage : rtck_pkg

/* src/rtck_xtal_sync.sv */
// crystal clock synchroniser and rising edge detector
`timescale 1ns/100ps
module rtck_xtal_sync import rtck_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic xtal_in,
    output logic xtal_rise
);
    rtck_sync_t st;
    rtck_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = xtal_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.rise = 1'b0;
        // the level moves only once the second and third stages agree
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
            next_st.rise = st.s3 && !st.level;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign xtal_rise = st.rise;
endmodule : rtck_xtal_sync

/* bench/rtc_timekeeping_core_test.sv */
// self-checking testbench for the real-time clock timekeeping core
`timescale 1ns/100ps
module rtc_timekeeping_core_test import rtck_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic warm_rst_n = 1'b1;
    logic xtal_in = 1'b0;
    logic xtal_run = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic midnight_flag;
    logic alarm_flag;
    logic [7:0] irq_pin_config;
    logic deep_sleep_ok;
    logic rd_fire = 1'b0;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // rollover table: day length, start hour, hour after, midnight seen
    logic tbl_dls[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    logic [7:0] tbl_h[4] = '{8'h17, 8'hff, 8'h17, 8'hfe};
    logic [7:0] tbl_exp[4] = '{8'h00, 8'h00, 8'h18, 8'hff};
    logic tbl_mid[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0] plain_addr[3] = '{RTCK_ADDR_INTERVAL, RTCK_ADDR_NOM_TRIM,
                                  RTCK_ADDR_THERM_TRIM};

    rtck_core dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .warm_rst_n(warm_rst_n),
        .xtal_in(xtal_in),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .midnight_flag(midnight_flag),
        .alarm_flag(alarm_flag),
        .irq_pin_config(irq_pin_config),
        .deep_sleep_ok(deep_sleep_ok)
    );

    always #2 core_clk = ~core_clk;
    // fractional half period puts only every 20th crystal edge on a core clock edge
    always #16.3 xtal_in = xtal_run ? ~xtal_in : 1'b0;

    task conclude;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        rd_fire <= sfr_rd;
        if (cycles == 100000) begin
            num_errors++;
            conclude();
        end
    end

    // read data is registered at the read edge, so it is settled here
    always @(negedge core_clk) begin
        if (rd_fire === 1'b1 && exp_q.size() != 0) begin
            chk(sfr_rdata, exp_q.pop_front());
        end
    end

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_wr = 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        @(posedge core_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_rd = 1'b0;
    endtask : rd

    task pw(input logic [7:0] a, input logic [7:0] d);
        wr(RTCK_ADDR_KEY, RTCK_TIME_KEY);
        wr(a, d);
        wr(RTCK_ADDR_KEY, RTCK_KEY_RST);
    endtask : pw

    // centiseconds last: that write also clears the sub-tick divider
    task settime(input logic [7:0] h, m, s, c);
        pw(RTCK_ADDR_HOUR, h);
        pw(RTCK_ADDR_MIN, m);
        pw(RTCK_ADDR_SEC, s);
        pw(RTCK_ADDR_CENTI, c);
    endtask : settime

    task rdtime(input logic [7:0] h, m, s, c);
        rd(RTCK_ADDR_HOUR, h);
        rd(RTCK_ADDR_MIN, m);
        rd(RTCK_ADDR_SEC, s);
        rd(RTCK_ADDR_CENTI, c);
    endtask : rdtime

    task por;
        @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
    endtask : por

    // 400 crystal rises give exactly one hundredth tick from a clean divider
    task run_xtal(input int n);
        xtal_run = 1'b1;
        repeat (n) @(posedge xtal_in);
        xtal_run = 1'b0;
        cyc(10);
    endtask : run_xtal

    task wait_alarm(input int n);
        // the flag is looked at off the edge that updates it
        for (int i = 0; i < n && alarm_flag !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
    endtask : wait_alarm

    initial begin
        logic [7:0] h, m, s, c, v;
        logic mid;
        void'($urandom(19));
        cyc(3);
        rst_n = 1'b1;
        rd(RTCK_ADDR_CONFIG, RTCK_CONFIG_RST);
        rdtime(8'h00, 8'h00, 8'h00, 8'h00);
        chk(irq_pin_config, RTCK_IRQ_CFG_RST);
        chk({7'h00, deep_sleep_ok}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            v = 8'($urandom);
            wr(plain_addr[i], v);
            rd(plain_addr[i], v);
            wr(plain_addr[i], 8'h00);
        end
        wr(8'h10, 8'h5a);
        rd(8'h10, RTCK_RDATA_RST);
        wr(RTCK_ADDR_SEC, 8'h12);
        rd(RTCK_ADDR_SEC, 8'h00);
        wr(RTCK_ADDR_IRQ_CFG, 8'h80);
        chk(irq_pin_config, 8'h00);
        pw(RTCK_ADDR_IRQ_CFG, 8'h80);
        chk(irq_pin_config, 8'h80);
        rd(RTCK_ADDR_KEY, RTCK_KEY_RST);
        for (int i = 0; i < 4; i++) begin
            v = {2'b01, 2'(i), 4'h1};
            wr(RTCK_ADDR_CONFIG, v);
            rd(RTCK_ADDR_CONFIG, v);
        end
        h = 8'($urandom % 24);
        m = 8'($urandom % 60);
        s = 8'($urandom % 60);
        c = 8'($urandom % 100);
        settime(h, m, s, c);
        wr(RTCK_ADDR_CONFIG, 8'h41);
        warm_rst_n = 1'b0;
        cyc(1);
        warm_rst_n = 1'b1;
        rdtime(h, m, s, c);
        rd(RTCK_ADDR_CONFIG, 8'h41);
        cyc(3);
        por();
        rdtime(8'h00, 8'h00, 8'h00, 8'h00);
        rd(RTCK_ADDR_CONFIG, RTCK_CONFIG_RST);
        // clean divider: +254 at rises 256 and 512 gives two ticks by 651
        wr(RTCK_ADDR_NOM_TRIM, 8'h7f);
        wr(RTCK_ADDR_THERM_TRIM, 8'h7f);
        run_xtal(652);
        rdtime(8'h00, 8'h00, 8'h00, 8'h02);
        wr(RTCK_ADDR_NOM_TRIM, 8'h00);
        wr(RTCK_ADDR_THERM_TRIM, 8'h00);
        for (int i = 0; i < 4; i++) begin
            mid = tbl_mid[i];
            wr(RTCK_ADDR_CONFIG, {1'b0, tbl_dls[i], 6'h01});
            settime(tbl_h[i], RTCK_MIN_MAX, RTCK_SEC_MAX, RTCK_CENTI_MAX);
            run_xtal(400);
            rdtime(tbl_exp[i], 8'h00, 8'h00, 8'h00);
            chk({7'h00, midnight_flag}, {7'h00, mid});
            chk({7'h00, deep_sleep_ok}, {7'h00, ~mid});
            rd(RTCK_ADDR_CONFIG, {mid, tbl_dls[i], 6'h01});
            wr(RTCK_ADDR_CONFIG, {1'b0, tbl_dls[i], 6'h01});
            cyc(2);
            chk({7'h00, midnight_flag}, 8'h00);
            chk({7'h00, deep_sleep_ok}, 8'h01);
        end
        // interval 1: the first tick of the chosen base sets the alarm
        wr(RTCK_ADDR_INTERVAL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(RTCK_ADDR_CONFIG, 8'h41);
            settime(8'h00, (i == 3) ? RTCK_MIN_MAX : 8'h00,
                    (i >= 2) ? RTCK_SEC_MAX : 8'h00, RTCK_CENTI_MAX);
            wr(RTCK_ADDR_CONFIG, {2'b01, 2'(i), 4'h3});
            run_xtal(400);
            chk({7'h00, alarm_flag}, 8'h01);
        end
        wr(RTCK_ADDR_CONFIG, 8'h41);
        // two 1/128 s ticks per alarm, roughly 4200 core cycles
        wr(RTCK_ADDR_INTERVAL, 8'h02);
        wr(RTCK_ADDR_CONFIG, 8'h4b);
        xtal_run = 1'b1;
        wait_alarm(8000);
        chk({7'h00, alarm_flag}, 8'h01);
        rd(RTCK_ADDR_CONFIG, 8'h4f);
        wr(RTCK_ADDR_CONFIG, 8'h4b);
        cyc(12000);
        chk({7'h00, alarm_flag}, 8'h00);
        wr(RTCK_ADDR_CONFIG, 8'h41);
        wr(RTCK_ADDR_CONFIG, 8'h43);
        wait_alarm(8000);
        chk({7'h00, alarm_flag}, 8'h01);
        wr(RTCK_ADDR_CONFIG, 8'h43);
        wait_alarm(8000);
        chk({7'h00, alarm_flag}, 8'h01);
        wr(RTCK_ADDR_CONFIG, 8'h41);
        cyc(12000);
        chk({7'h00, alarm_flag}, 8'h00);
        wr(RTCK_ADDR_CONFIG, 8'h45);
        rd(RTCK_ADDR_CONFIG, 8'h41);
        chk({7'h00, alarm_flag}, 8'h00);
        wr(RTCK_ADDR_CONFIG, 8'h53);
        cyc(12000);
        chk({7'h00, alarm_flag}, 8'h00);
        wr(RTCK_ADDR_CONFIG, 8'h41);
        xtal_run = 1'b0;
        cyc(5);
        chk(8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule : rtc_timekeeping_core_test
